// *** verilog/erp_defs.vh ***
`ifndef ERP_DEFS_VH
`define ERP_DEFS_VH

// ----------------------------------------------------------------------
// Subaddress map
// ----------------------------------------------------------------------
`define ERP_SUB_POWER      8'h00
`define ERP_SUB_MODE       8'h01
`define ERP_SUB_LAST       8'h01

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define ERP_RST_POWER      8'h12
`define ERP_RST_MODE       8'h00
`define ERP_RST_POINTER    8'h00

// ----------------------------------------------------------------------
// Power-mode field positions
// ----------------------------------------------------------------------
`define ERP_PWR_SLEEP      0
`define ERP_PWR_PLL_OFF    1
`define ERP_PWR_DAC3       2
`define ERP_PWR_DAC2       3
`define ERP_PWR_DAC1       4
`define ERP_PWR_DAC6       5
`define ERP_PWR_DAC5       6
`define ERP_PWR_DAC4       7

// ----------------------------------------------------------------------
// Mode-select field positions and codes
// ----------------------------------------------------------------------
`define ERP_MODE_EDGE_LO   1
`define ERP_MODE_EDGE_HI   2
`define ERP_MODE_INPUT_LO  4
`define ERP_MODE_INPUT_HI  6
`define ERP_EDGE_CHROMA_RISE 2'h0
`define ERP_EDGE_LUMA_RISE   2'h3
`define ERP_INMODE_LAST    3'h3

`endif

// *** verilog/erp_reg_cell.v ***
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------------
// One host-writable register with its own reset value
// ----------------------------------------------------------------------
module erp_reg_cell #(
  parameter WIDTH = 8,
  parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
  input  wire             clk_sys,
  input  wire             rst_b,
  input  wire             writeEnable,
  input  wire [WIDTH-1:0] writeData,
  output reg  [WIDTH-1:0] value
);

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      value <= RESET_VALUE;
    end else if (writeEnable) begin
      value <= writeData;
    end
  end

endmodule // erp_reg_cell

`default_nettype wire

// *** verilog/erp_reg_access.v ***
`timescale 1ns/10ps
`default_nettype none

`include "erp_defs.vh"

// Summary of operation
// - Each write transaction starts by loading the pointer; data goes where it points.
// - After each acked data byte and each read below the top, the target address advances by one.
// - Pointer is an 8-bit write-only register, never returned on reads.
// - Pointer loads once addressed and direction known, before any data byte.
// - Registers are readable and writable unless designated otherwise.
// - Reads of write-only registers denied; writes to read-only ignored.
// - Power bit 0 set enters sleep: all DACs and PLL disabled.
// - In sleep, host writes and reads still work normally.
// - Power bit 1: 0 keeps PLL running, 1 powers PLL and oversampling down.
// - Power bits 2..7 enable DAC 3,2,1,6,5,4 when set.
// - Edge field 00: chroma on rising edge, luma on falling, DDR only.
// - Edge field 11: luma rising, chroma falling; 01 and 10 reserved.
// - Mode bits 6:4 pick the input mode, codes 000 to 011.
// - Invalid subaddress byte is not acknowledged; device returns to idle.
// - Reads past the top keep returning the highest register until NACK.
// - Writes past the top are discarded, not acknowledged, back to idle.
// - First byte is device address, second is starting subaddress.
module erp_reg_access #(
  parameter [7:0] LAST_SUBADDR = `ERP_SUB_LAST
) (
  input  wire       clk_sys,
  input  wire       rst_b,
  input  wire       txnStart,
  input  wire       txnRead,
  input  wire       txnStop,
  input  wire       masterNack,
  input  wire       wrByteValid,
  input  wire [7:0] wrByte,
  input  wire       rdByteReq,
  output reg        wrAck,
  output reg        wrNack,
  output reg        rdValid,
  output reg  [7:0] rdData,
  output reg        portBusy,
  output reg        sleepActive,
  output reg        pllRunning,
  output reg        oversampleOn,
  output reg  [5:0] dacPowerOn,
  output reg        chromaOnRise,
  output reg        lumaOnRise,
  output reg        edgeCodeReserved,
  output reg  [2:0] inputMode,
  output reg        inputModeReserved
);

  // --------------------------------------------------------------------
  // Transaction states
  // --------------------------------------------------------------------
  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_PTR   = 2'h1;
  localparam [1:0] ST_WDATA = 2'h2;
  localparam [1:0] ST_RDATA = 2'h3;

  reg  [1:0] state;
  reg  [1:0] next_state;
  reg  [7:0] pointer;
  reg  [7:0] next_pointer;
  reg        next_wrAck;
  reg        next_wrNack;
  reg        next_rdValid;
  reg  [7:0] next_rdData;
  reg        writePower;
  reg        writeMode;
  reg  [7:0] readSel;
  reg  [7:0] readValue;
  reg        next_sleepActive;
  reg        next_pllRunning;
  reg        next_oversampleOn;
  reg  [5:0] next_dacPowerOn;
  reg        next_chromaOnRise;
  reg        next_lumaOnRise;
  reg        next_edgeCodeReserved;
  reg  [2:0] next_inputMode;
  reg        next_inputModeReserved;

  wire [7:0] powerReg;
  wire [7:0] modeReg;
  wire       ptrValid;
  wire       byteValidAddr;
  wire [7:0] pointerPlus;
  wire [1:0] edgeField;
  wire [2:0] inputField;

  assign ptrValid      = (pointer <= LAST_SUBADDR);
  assign byteValidAddr = (wrByte <= LAST_SUBADDR);
  assign pointerPlus   = pointer + 8'h01;
  assign edgeField     = modeReg[`ERP_MODE_EDGE_HI:`ERP_MODE_EDGE_LO];
  assign inputField    = modeReg[`ERP_MODE_INPUT_HI:`ERP_MODE_INPUT_LO];

  // --------------------------------------------------------------------
  // Register storage
  // --------------------------------------------------------------------
  // No register gates writes on the sleep bit, so configuration can be
  // prepared while the analog side is powered down.
  erp_reg_cell #(
    .WIDTH       (8),
    .RESET_VALUE (`ERP_RST_POWER)
  ) u_power (
    .clk_sys     (clk_sys),
    .rst_b       (rst_b),
    .writeEnable (writePower),
    .writeData   (wrByte),
    .value       (powerReg)
  );

  erp_reg_cell #(
    .WIDTH       (8),
    .RESET_VALUE (`ERP_RST_MODE)
  ) u_mode (
    .clk_sys     (clk_sys),
    .rst_b       (rst_b),
    .writeEnable (writeMode),
    .writeData   (wrByte),
    .value       (modeReg)
  );

  // --------------------------------------------------------------------
  // Read mux
  // --------------------------------------------------------------------
  // The pointer itself has no subaddress, so it can never be selected.
  always @* begin
    if (ptrValid) begin
      readSel = pointer;
    end else begin
      readSel = LAST_SUBADDR;
    end
    case (readSel)
      `ERP_SUB_POWER: begin
        readValue = powerReg;
      end
      `ERP_SUB_MODE: begin
        readValue = modeReg;
      end
      default: begin
        readValue = 8'h00;
      end
    endcase
  end

  // --------------------------------------------------------------------
  // Transaction control
  // --------------------------------------------------------------------
  // Stop beats start beats bytes; a repeated start restarts cleanly.
  always @* begin
    next_state   = state;
    next_pointer = pointer;
    next_wrAck   = 1'b0;
    next_wrNack  = 1'b0;
    next_rdValid = 1'b0;
    next_rdData  = rdData;
    writePower   = 1'b0;
    writeMode    = 1'b0;
    if (txnStop) begin
      next_state = ST_IDLE;
    end else if (txnStart) begin
      if (txnRead) begin
        next_state = ST_RDATA;
      end else begin
        next_state = ST_PTR;
      end
    end else begin
      case (state)
        ST_IDLE: begin
          next_state = ST_IDLE;
        end
        ST_PTR: begin
          if (wrByteValid) begin
            if (byteValidAddr) begin
              next_pointer = wrByte;
              next_wrAck   = 1'b1;
              next_state   = ST_WDATA;
            end else begin
              next_wrNack  = 1'b1;
              next_state   = ST_IDLE;
            end
          end
        end
        ST_WDATA: begin
          if (wrByteValid) begin
            if (ptrValid) begin
              writePower   = (pointer == `ERP_SUB_POWER);
              writeMode    = (pointer == `ERP_SUB_MODE);
              next_wrAck   = 1'b1;
              next_pointer = pointerPlus;
            end else begin
              next_wrNack  = 1'b1;
              next_state   = ST_IDLE;
            end
          end
        end
        ST_RDATA: begin
          if (masterNack) begin
            next_state = ST_IDLE;
          end else if (rdByteReq) begin
            next_rdData  = readValue;
            next_rdValid = 1'b1;
            if (pointer < LAST_SUBADDR) begin
              next_pointer = pointerPlus;
            end else begin
              next_pointer = LAST_SUBADDR;
            end
          end
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      state    <= ST_IDLE;
      pointer  <= `ERP_RST_POINTER;
      wrAck    <= 1'b0;
      wrNack   <= 1'b0;
      rdValid  <= 1'b0;
      rdData   <= 8'h00;
      portBusy <= 1'b0;
    end else begin
      state    <= next_state;
      pointer  <= next_pointer;
      wrAck    <= next_wrAck;
      wrNack   <= next_wrNack;
      rdValid  <= next_rdValid;
      rdData   <= next_rdData;
      portBusy <= (next_state != ST_IDLE);
    end
  end

  // --------------------------------------------------------------------
  // Power and input-mode decode
  // --------------------------------------------------------------------
  // Sleep masks the single enables without touching the stored bits, so
  // waking up restores the DAC and PLL selection the host left behind.
  always @* begin
    next_sleepActive   = powerReg[`ERP_PWR_SLEEP];
    next_pllRunning    = ~powerReg[`ERP_PWR_SLEEP] & ~powerReg[`ERP_PWR_PLL_OFF];
    next_oversampleOn  = ~powerReg[`ERP_PWR_SLEEP] & ~powerReg[`ERP_PWR_PLL_OFF];
    next_dacPowerOn[0] = powerReg[`ERP_PWR_DAC1] & ~powerReg[`ERP_PWR_SLEEP];
    next_dacPowerOn[1] = powerReg[`ERP_PWR_DAC2] & ~powerReg[`ERP_PWR_SLEEP];
    next_dacPowerOn[2] = powerReg[`ERP_PWR_DAC3] & ~powerReg[`ERP_PWR_SLEEP];
    next_dacPowerOn[3] = powerReg[`ERP_PWR_DAC4] & ~powerReg[`ERP_PWR_SLEEP];
    next_dacPowerOn[4] = powerReg[`ERP_PWR_DAC5] & ~powerReg[`ERP_PWR_SLEEP];
    next_dacPowerOn[5] = powerReg[`ERP_PWR_DAC6] & ~powerReg[`ERP_PWR_SLEEP];
    case (edgeField)
      `ERP_EDGE_CHROMA_RISE: begin
        next_chromaOnRise     = 1'b1;
        next_lumaOnRise       = 1'b0;
        next_edgeCodeReserved = 1'b0;
      end
      `ERP_EDGE_LUMA_RISE: begin
        next_chromaOnRise     = 1'b0;
        next_lumaOnRise       = 1'b1;
        next_edgeCodeReserved = 1'b0;
      end
      default: begin
        // Reserved edge codes leave both edge selects low
        next_chromaOnRise     = 1'b0;
        next_lumaOnRise       = 1'b0;
        next_edgeCodeReserved = 1'b1;
      end
    endcase
    next_inputMode         = inputField;
    next_inputModeReserved = (inputField > `ERP_INMODE_LAST);
  end

  // --------------------------------------------------------------------
  // Registered controls
  // --------------------------------------------------------------------
  // Registered so every control leaving the block is glitch free; the
  // cost is one cycle between a register write and its effect.
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      sleepActive       <= 1'b0;
      pllRunning        <= 1'b0;
      oversampleOn      <= 1'b0;
      dacPowerOn        <= 6'h00;
      chromaOnRise      <= 1'b0;
      lumaOnRise        <= 1'b0;
      edgeCodeReserved  <= 1'b0;
      inputMode         <= 3'h0;
      inputModeReserved <= 1'b0;
    end else begin
      sleepActive       <= next_sleepActive;
      pllRunning        <= next_pllRunning;
      oversampleOn      <= next_oversampleOn;
      dacPowerOn        <= next_dacPowerOn;
      chromaOnRise      <= next_chromaOnRise;
      lumaOnRise        <= next_lumaOnRise;
      edgeCodeReserved  <= next_edgeCodeReserved;
      inputMode         <= next_inputMode;
      inputModeReserved <= next_inputModeReserved;
    end
  end

endmodule // erp_reg_access

`default_nettype wire

// *** verification/erp_reg_access_monitor.sv ***
`timescale 1ns/10ps
`default_nettype none
module erp_reg_access_monitor #(
  parameter [7:0] LAST_SUBADDR = 8'h01
) (
  input wire logic       clk_sys,
  input wire logic       rst_b,
  input wire logic       txnStart,
  input wire logic       txnStop,
  input wire logic       wrByteValid,
  input wire logic       rdByteReq,
  input wire logic       wrAck,
  input wire logic       wrNack,
  input wire logic       rdValid,
  input wire logic       portBusy,
  input wire logic       sleepActive,
  input wire logic       pllRunning,
  input wire logic       oversampleOn,
  input wire logic [5:0] dacPowerOn,
  input wire logic       chromaOnRise,
  input wire logic       lumaOnRise,
  input wire logic       edgeCodeReserved,
  input wire logic [2:0] inputMode,
  input wire logic       inputModeReserved
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // ----
  // Port answers
  // ----
  a_start_busy: assert property (txnStart && !txnStop |=> portBusy)
    else $error("port not busy after start");
  a_stop_idle: assert property (txnStop |=> !portBusy)
    else $error("port busy after stop");
  a_nack_idle: assert property (wrNack |-> !portBusy)
    else $error("busy after refused byte");
  a_ans_cause: assert property ((wrAck || wrNack) |-> $past(wrByteValid))
    else $error("write answer without byte");
  a_ans_excl: assert property (!(wrAck && wrNack))
    else $error("ack and nack together");
  a_rd_cause: assert property (rdValid |-> $past(rdByteReq))
    else $error("read data without request");
  // ----
  // Decoded controls
  // ----
  a_sleep_off: assert property (sleepActive |-> dacPowerOn == 6'h00 && !pllRunning)
    else $error("sleep left dac or pll on");
  a_pll_pair: assert property (pllRunning == oversampleOn)
    else $error("pll and oversampling differ");
  a_edge_excl: assert property (chromaOnRise |-> !lumaOnRise && !edgeCodeReserved)
    else $error("edge decode overlaps");
  a_mode_res: assert property (inputModeReserved == inputMode[2])
    else $error("input mode reserved flag wrong");
endmodule // erp_reg_access_monitor
`default_nettype wire

// *** verification/erp_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module erp_host_model (
  input  wire logic       clk_sys,
  input  wire logic       wrAck,
  input  wire logic       wrNack,
  input  wire logic       rdValid,
  input  wire logic [7:0] rdData,
  output var  logic       txnStart,
  output var  logic       txnRead,
  output var  logic       txnStop,
  output var  logic       masterNack,
  output var  logic       wrByteValid,
  output var  logic [7:0] wrByte,
  output var  logic       rdByteReq
);
  initial begin
    {txnStart, txnRead, txnStop, masterNack, wrByteValid, rdByteReq} = 6'h00;
    wrByte = 8'h5a;
  end
  task automatic start(input logic rd);
    @(posedge clk_sys);
    txnStart <= 1'b1;
    txnRead <= rd;
    @(posedge clk_sys);
    txnStart <= 1'b0;
  endtask
  // Released data shows the inverse so a stale byte never passes as fresh
  task automatic sendByte(input logic [7:0] b, output logic [1:0] ans);
    @(posedge clk_sys);
    wrByteValid <= 1'b1;
    wrByte <= b;
    @(posedge clk_sys);
    wrByteValid <= 1'b0;
    wrByte <= ~b;
    #1 ans = {wrAck, wrNack};
  endtask
  task automatic getByte(output logic [7:0] d, output logic v);
    @(posedge clk_sys);
    rdByteReq <= 1'b1;
    @(posedge clk_sys);
    rdByteReq <= 1'b0;
    #1 d = rdData;
    v = rdValid;
  endtask
  task automatic finish(input logic nack);
    @(posedge clk_sys);
    masterNack <= nack;
    txnStop <= ~nack;
    @(posedge clk_sys);
    masterNack <= 1'b0;
    txnStop <= 1'b0;
  endtask
endmodule // erp_host_model
`default_nettype wire

// *** verification/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "erp_defs.vh"
module testbench;
  logic        clk_sys, rst_b, txnStart, txnRead, txnStop, masterNack, wrByteValid, rdByteReq;
  logic        wrAck, wrNack, rdValid, portBusy, sleepActive, pllRunning, oversampleOn, v;
  logic        chromaOnRise, lumaOnRise, edgeCodeReserved, inputModeReserved;
  logic [7:0]  wrByte, rdData, p, m, d;
  logic [5:0]  dacPowerOn;
  logic [2:0]  inputMode;
  logic [1:0]  ans;
  logic [15:0] dec;
  integer      errors, num_checks, seed, i;
  assign dec = {sleepActive, pllRunning, oversampleOn, dacPowerOn, chromaOnRise, lumaOnRise,
                edgeCodeReserved, inputMode, inputModeReserved};
  erp_reg_access dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .txnStart(txnStart),
    .txnRead(txnRead), .txnStop(txnStop), .masterNack(masterNack), .wrByteValid(wrByteValid),
    .wrByte(wrByte), .rdByteReq(rdByteReq), .wrAck(wrAck), .wrNack(wrNack), .rdValid(rdValid),
    .rdData(rdData), .portBusy(portBusy), .sleepActive(sleepActive), .pllRunning(pllRunning),
    .oversampleOn(oversampleOn), .dacPowerOn(dacPowerOn), .chromaOnRise(chromaOnRise),
    .lumaOnRise(lumaOnRise), .edgeCodeReserved(edgeCodeReserved), .inputMode(inputMode),
    .inputModeReserved(inputModeReserved));
  erp_host_model host_u (.clk_sys(clk_sys), .wrAck(wrAck), .wrNack(wrNack), .rdValid(rdValid),
    .rdData(rdData), .txnStart(txnStart), .txnRead(txnRead), .txnStop(txnStop),
    .masterNack(masterNack), .wrByteValid(wrByteValid), .wrByte(wrByte), .rdByteReq(rdByteReq));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  function automatic logic [15:0] expDec(input logic [7:0] pw, input logic [7:0] md);
    logic s;
    s = pw[0];
    return {s, ~s & ~pw[1], ~s & ~pw[1], {pw[5], pw[6], pw[7], pw[2], pw[3], pw[4]} & {6{~s}},
            md[2:1] == 2'h0, md[2:1] == 2'h3, md[2] ^ md[1], md[6:4], md[6]};
  endfunction
  task automatic checkVal(input string name, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic checkDec(input logic [15:0] exp);
    num_checks++;
    if (dec !== exp) begin
      errors++;
      $display("ERROR decoded controls expected %h seen %h", exp, dec);
    end
  endtask
  task automatic end_of_test;
    $display("errors %0d checks %0d", errors, num_checks);
    if (errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic sendChk(input logic [7:0] b, input logic [1:0] exp);
    host_u.sendByte(b, ans);
    checkVal("write answer", {6'h00, exp}, {6'h00, ans});
  endtask
  // Write transaction opened and its pointer byte sent
  task automatic setPtr(input logic [7:0] sub, input logic [1:0] exp);
    host_u.start(1'b0);
    sendChk(sub, exp);
  endtask
  // Read from the stored pointer; ends by NACK or by stop, picked at random
  task automatic readBack(input logic [7:0] ep, input logic [7:0] em);
    host_u.start(1'b1);
    host_u.getByte(d, v);
    checkVal("read power", ep, d);
    host_u.getByte(d, v);
    checkVal("read mode", em, d);
    host_u.getByte(d, v);
    checkVal("read past top", em, d);
    checkVal("read valid", 8'h01, {7'h00, v});
    host_u.finish(p[0]);
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    end_of_test;
  end
  initial begin
    errors = 0;
    num_checks = 0;
    seed = 54;
    p = `ERP_RST_POWER;
    rst_b = 1'b0;
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    #1 checkDec(expDec(`ERP_RST_POWER, `ERP_RST_MODE));
    setPtr(`ERP_SUB_POWER, 2'b10);
    readBack(`ERP_RST_POWER, `ERP_RST_MODE);
    for (i = 0; i < 12; i++) begin
      p = $random(seed);
      // Reserved bits kept zero and only the two legal edge codes used
      m = {2'b00, i[1:0], 1'b0, {2{p[7]}}, 1'b0};
      setPtr(`ERP_SUB_POWER, 2'b10);
      sendChk(p, 2'b10);
      sendChk(m, 2'b10);
      sendChk(~m, 2'b01);
      sendChk(m, 2'b00);
      host_u.finish(p[1]);
      repeat (2) @(posedge clk_sys);
      #1 checkDec(expDec(p, m));
      setPtr(`ERP_SUB_POWER, 2'b10);
      readBack(p, m);
      setPtr(`ERP_SUB_POWER, 2'b10);
      setPtr(8'h02 | p, 2'b01);
      // Repeated start right after the refused pointer reads from the kept one
      readBack(p, m);
    end
    // Reserved codes on purpose: they must be stored, read back and flagged
    setPtr(`ERP_SUB_MODE, 2'b10);
    sendChk(8'h7a, 2'b10);
    host_u.finish(1'b0);
    repeat (2) @(posedge clk_sys);
    #1 checkDec(expDec(p, 8'h7a));
    checkVal("busy after stop", 8'h00, {7'h00, portBusy});
    setPtr(`ERP_SUB_POWER, 2'b10);
    readBack(p, 8'h7a);
    // Reset in mid-run brings registers and decode back to their defaults
    @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    #1 checkDec(expDec(`ERP_RST_POWER, `ERP_RST_MODE));
    setPtr(`ERP_SUB_POWER, 2'b10);
    readBack(`ERP_RST_POWER, `ERP_RST_MODE);
    end_of_test;
  end
endmodule // testbench
bind erp_reg_access erp_reg_access_monitor #(.LAST_SUBADDR(LAST_SUBADDR)) mon_u (
  .clk_sys(clk_sys), .rst_b(rst_b), .txnStart(txnStart), .txnStop(txnStop),
  .wrByteValid(wrByteValid), .rdByteReq(rdByteReq), .wrAck(wrAck), .wrNack(wrNack),
  .rdValid(rdValid), .portBusy(portBusy), .sleepActive(sleepActive), .pllRunning(pllRunning),
  .oversampleOn(oversampleOn), .dacPowerOn(dacPowerOn), .chromaOnRise(chromaOnRise),
  .lumaOnRise(lumaOnRise), .edgeCodeReserved(edgeCodeReserved), .inputMode(inputMode),
  .inputModeReserved(inputModeReserved));
`default_nettype wire
